// ---- design/rapd_pkg.sv ----
// package for the radio converter control block
// assumes a 100 MHz system clock and a 32-bit apb register bus
package rapd_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD    = 8'h00;
  localparam logic [7:0] ADDR_RESP   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CTRL   = 8'h0C;
  localparam logic [7:0] ADDR_RES1   = 8'h10;
  localparam logic [7:0] ADDR_RES5   = 8'h20;

  // ----------------------------------------------------------------
  // command word layout
  // ----------------------------------------------------------------
  localparam int D1_LSB = 0;
  localparam int D2_LSB = 8;
  localparam int D3_LSB = 16;
  localparam logic [1:0] CLASS_NORMAL  = 2'b01;
  localparam logic [1:0] CLASS_SETUP   = 2'b10;
  localparam logic [1:0] SETUP_PLAIN   = 2'b00;
  localparam logic [1:0] SETUP_RESTART = 2'b11;
  localparam int RESP_VALID_BIT = 31;
  localparam logic [3:0] PREAMBLE_HEAD = 4'b1010;

  // status bits
  localparam int ST_LOCK   = 0;
  localparam int ST_SLEEP  = 1;
  localparam int ST_OSC    = 2;
  localparam int ST_BOOST  = 3;
  localparam int ST_CARR   = 4;
  localparam int ST_WIN84  = 5;
  localparam int CTRL_SLEEP = 0;

  // ----------------------------------------------------------------
  // converter, filter and oscillator constants
  // ----------------------------------------------------------------
  localparam int NUM_CH        = 5;
  localparam int SEQ_LEN       = 12;
  // scan order 5,1,5,2,5,1,5,3,5,1,5,4, entry 0 in the low bits
  localparam logic [35:0] SEQ_PATTERN = {3'd4, 3'd5, 3'd1, 3'd5, 3'd3, 3'd5,
                                         3'd1, 3'd5, 3'd2, 3'd5, 3'd1, 3'd5};
  localparam logic [2:0] SAR_SUB_LAST = 3'd4;   // 5 bus clocks per bit, 40 per slot
  localparam logic [7:0] SAR_START    = 8'h80;
  localparam logic [6:0] WIN_SHORT    = 7'd80;
  localparam logic [6:0] WIN_LONG     = 7'd84;
  localparam logic [10:0] BOOST_LAST  = 11'd2046; // 2047 oscillation cycles
  localparam logic [6:0] LOCK_THR_RST = 7'd0;
  localparam logic [7:0] CARR_THR_RST = 8'h00;

endpackage

// ---- design/rapd_top.sv ----
// converter control logic: polling adc sequencer, lock filter, dacs, oscillator control
// assumes serial bus clock, crystal clock, comparator and lock inputs are asynchronous pins
// Notes on behaviour
// - scan order 5,1,5,2,5,1,5,3,5,1,5,4 repeating
// - 8-bit result stored per channel register
// - conversion stepped by serial bus clock, SAR
// - setup xx1xxx00 sets window 80 or 84
// - normal 01x1xxxx loads 7-bit lock threshold
// - setup selects input B/A for channels 3,2
// - normal command code selects result pair
// - preamble 1010,code,0,lock then two results
// - echo code; result one is channel five
// - carrier detect high while channel one above threshold
// - normal command loads first byte into dacs
// - sleep: dac three off, others reduced drive
// - outside sleep, bit loads dac three power
// - oscillator boost for first 2047 cycles
// - oscillator on at reset, setup ending 00 sets it from bit 7
// - every result readable at any time
// - lock sampled at half bus clock, counted
// - setup ending 11 restarts to reset state
//
// Implementation choices: the APB register port and the address map.
module rapd_top
  import rapd_pkg::*;
#(
  parameter int RESP_DELAY = 8
)(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        serial_bus_clock,
  input  wire logic        crystal_reference_clock,
  input  wire logic        adc_comp_in,
  input  wire logic        lock_raw,
  output logic [2:0]       adc_channel_sel,
  output logic [7:0]       adc_trial_code,
  output logic             channel_two_select_b,
  output logic             channel_three_select_b,
  output logic             carrier_detect_out,
  output logic [7:0]       dac_one,
  output logic [7:0]       dac_two,
  output logic [7:0]       dac_three,
  output logic             dac_three_powered,
  output logic             dac_reduced_drive,
  output logic             osc_enable,
  output logic             osc_boost
);

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0] sbc_s_r;
  logic [1:0] xo_s_r;
  logic [1:0] cmp_s_r;
  logic [1:0] lck_s_r;
  logic       sbc_prev_r;
  logic       xo_prev_r;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sbc_s_r    <= 2'b00;
      xo_s_r     <= 2'b00;
      cmp_s_r    <= 2'b00;
      lck_s_r    <= 2'b00;
      sbc_prev_r <= 1'b0;
      xo_prev_r  <= 1'b0;
    end
    else
    begin
      sbc_s_r    <= {sbc_s_r[0], serial_bus_clock};
      xo_s_r     <= {xo_s_r[0], crystal_reference_clock};
      cmp_s_r    <= {cmp_s_r[0], adc_comp_in};
      lck_s_r    <= {lck_s_r[0], lock_raw};
      sbc_prev_r <= sbc_s_r[1];
      xo_prev_r  <= xo_s_r[1];
    end
  end

  wire sbc_edge = sbc_s_r[1] & ~sbc_prev_r;
  wire xo_edge  = xo_s_r[1] & ~xo_prev_r;

  // ----------------------------------------------------------------
  // apb slave, one wait state
  // ----------------------------------------------------------------
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;

  wire        access   = psel & penable;
  wire        bus_done = access & pready_r;
  wire        cmd_wr   = bus_done & pwrite & (paddr == ADDR_CMD);
  wire        ctrl_wr  = bus_done & pwrite & (paddr == ADDR_CTRL);
  wire [7:0]  d1       = pwdata[D1_LSB +: 8];
  wire [7:0]  d2       = pwdata[D2_LSB +: 8];
  wire [7:0]  d3       = pwdata[D3_LSB +: 8];
  wire        is_norm  = cmd_wr & (d2[7:6] == CLASS_NORMAL);
  wire        is_setup = cmd_wr & (d2[7:6] == CLASS_SETUP);
  wire        setup_00 = is_setup & (d3[1:0] == SETUP_PLAIN);
  wire        restart  = is_setup & (d3[1:0] == SETUP_RESTART);
  wire        init     = rst | restart;

  // ----------------------------------------------------------------
  // control state set by commands
  // ----------------------------------------------------------------
  logic       sleep_r;
  logic       win_long_r;
  logic [6:0] lock_thr_r;
  logic [7:0] carr_thr_r;
  logic       sel2b_r;
  logic       sel3b_r;
  logic [7:0] dac_one_r;
  logic [7:0] dac_two_r;
  logic [7:0] dac_three_r;
  logic       dac_three_pwr_r;
  logic       osc_en_r;

  always_ff @(posedge clock)
  begin
    if (init)
    begin
      sleep_r    <= 1'b1;
      win_long_r <= 1'b0;
      lock_thr_r <= LOCK_THR_RST;
      carr_thr_r <= CARR_THR_RST;
      sel2b_r    <= 1'b0;
      sel3b_r    <= 1'b0;
      dac_one_r     <= 8'h00;
      dac_two_r     <= 8'h00;
      dac_three_r     <= 8'h00;
      dac_three_pwr_r <= 1'b0;
      osc_en_r   <= 1'b1;
    end
    else
    begin
      if (is_norm)
        sleep_r <= 1'b0;
      else if (ctrl_wr && pwdata[CTRL_SLEEP])
        sleep_r <= 1'b1;
      if (setup_00 && d3[5])
        win_long_r <= d1[5];
      if (is_norm && d2[4])
        lock_thr_r <= d1[7:1];
      if (is_norm && d3[4])
        carr_thr_r <= d1;
      if (setup_00)
      begin
        sel3b_r  <= d2[2];
        sel2b_r  <= d2[1];
        osc_en_r <= d3[7];
      end
      if (is_norm && d3[3])
        dac_one_r <= d1;
      if (is_norm && d3[2])
        dac_two_r <= d1;
      if (is_norm && d2[1])
        dac_three_r <= d1;
      if (is_norm)
        dac_three_pwr_r <= d2[3];
    end
  end

  // ----------------------------------------------------------------
  // polling sequencer with successive approximation
  // ----------------------------------------------------------------
  logic [3:0] slot_r;
  logic [2:0] sub_r;
  logic [2:0] bit_r;
  logic [7:0] trial_r;
  logic [7:0] res_r [NUM_CH];

  wire [2:0] cur_ch   = SEQ_PATTERN[3*slot_r +: 3];
  wire [2:0] cur_idx  = cur_ch - 3'd1;
  wire [7:0] bit_mask = 8'h01 << bit_r;
  wire [7:0] decided  = cmp_s_r[1] ? trial_r : (trial_r & ~bit_mask);
  wire [7:0] next_try = decided | (bit_mask >> 1);
  wire       sar_step = sbc_edge & (sub_r == SAR_SUB_LAST);
  wire       sar_end  = sar_step & (bit_r == 3'd0);

  always_ff @(posedge clock)
  begin
    if (init)
    begin
      slot_r  <= 4'd0;
      sub_r   <= 3'd0;
      bit_r   <= 3'd7;
      trial_r <= SAR_START;
    end
    else if (sbc_edge)
    begin
      sub_r <= (sub_r == SAR_SUB_LAST) ? 3'd0 : sub_r + 3'd1;
      if (sar_end)
      begin
        slot_r  <= (slot_r == 4'(SEQ_LEN - 1)) ? 4'd0 : slot_r + 4'd1;
        bit_r   <= 3'd7;
        trial_r <= SAR_START;
      end
      else if (sar_step)
      begin
        bit_r   <= bit_r - 3'd1;
        trial_r <= next_try;
      end
    end
  end

  generate
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_res
      always_ff @(posedge clock)
      begin
        if (init)
          res_r[c] <= 8'h00;
        else if (sar_end && cur_idx == 3'(c))
          res_r[c] <= decided;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // lock filter
  // ----------------------------------------------------------------
  logic       half_r;
  logic [6:0] win_cnt_r;
  logic [6:0] high_cnt_r;
  logic       lock_filt_r;

  wire [6:0] win_len   = win_long_r ? WIN_LONG : WIN_SHORT;
  wire       lk_sample = sbc_edge & half_r;
  wire [6:0] high_sum  = high_cnt_r + {6'd0, lck_s_r[1]};
  wire       win_end   = lk_sample & (win_cnt_r == win_len - 7'd1);

  always_ff @(posedge clock)
  begin
    if (init)
    begin
      half_r      <= 1'b0;
      win_cnt_r   <= 7'd0;
      high_cnt_r  <= 7'd0;
      lock_filt_r <= 1'b0;
    end
    else
    begin
      if (sbc_edge)
        half_r <= ~half_r;
      if (win_end)
      begin
        win_cnt_r   <= 7'd0;
        high_cnt_r  <= 7'd0;
        lock_filt_r <= (high_sum >= lock_thr_r);
      end
      else if (lk_sample)
      begin
        win_cnt_r  <= win_cnt_r + 7'd1;
        high_cnt_r <= high_sum;
      end
    end
  end

  // ----------------------------------------------------------------
  // crystal oscillator start-up boost
  // ----------------------------------------------------------------
  logic        boost_r;
  logic [10:0] boost_cnt_r;

  wire osc_turn_on = setup_00 & d3[7] & ~osc_en_r;

  always_ff @(posedge clock)
  begin
    if (init || osc_turn_on)
    begin
      boost_r     <= 1'b1;
      boost_cnt_r <= 11'd0;
    end
    else if (boost_r && xo_edge && osc_en_r)
    begin
      boost_cnt_r <= boost_cnt_r + 11'd1;
      if (boost_cnt_r == BOOST_LAST)
        boost_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // result pair response
  // ----------------------------------------------------------------
  logic [1:0]  req_code_r;
  logic [7:0]  resp_cnt_r;
  logic        resp_busy_r;
  logic [31:0] resp_r;

  wire [2:0]  pair_idx  = {1'b0, req_code_r} ;
  wire [7:0]  preamble  = {PREAMBLE_HEAD, req_code_r, 1'b0, lock_filt_r};
  wire [23:0] resp_word = {preamble, res_r[4], res_r[pair_idx]};
  wire        resp_fire = resp_busy_r & (resp_cnt_r == 8'(RESP_DELAY - 1));

  always_ff @(posedge clock)
  begin
    if (init)
    begin
      req_code_r  <= 2'b00;
      resp_cnt_r  <= 8'd0;
      resp_busy_r <= 1'b0;
      resp_r      <= 32'h0000_0000;
    end
    else if (is_norm)
    begin
      req_code_r  <= d3[1:0];
      resp_cnt_r  <= 8'd0;
      resp_busy_r <= 1'b1;
      resp_r      <= 32'h0000_0000;
    end
    else if (resp_fire)
    begin
      resp_busy_r <= 1'b0;
      resp_r      <= {8'h80, resp_word};
    end
    else if (resp_busy_r)
      resp_cnt_r <= resp_cnt_r + 8'd1;
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  logic [2:0] ch_sel_r;
  logic [7:0] try_out_r;
  logic       carr_r;
  logic       dac_three_on_r;
  logic       reduce_r;

  always_ff @(posedge clock)
  begin
    if (init)
    begin
      ch_sel_r  <= 3'd5;
      try_out_r <= SAR_START;
      carr_r    <= 1'b0;
      dac_three_on_r <= 1'b0;
      reduce_r  <= 1'b1;
    end
    else
    begin
      ch_sel_r  <= cur_ch;
      try_out_r <= trial_r;
      carr_r    <= (res_r[0] > carr_thr_r);
      dac_three_on_r <= dac_three_pwr_r & ~sleep_r;
      // same stage as dac_three_on_r so drive and power never disagree
      reduce_r  <= sleep_r;
    end
  end

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  wire        res_hit  = (paddr >= ADDR_RES1) && (paddr <= ADDR_RES5) && (paddr[1:0] == 2'b00);
  wire [2:0]  res_sel  = 3'((paddr - ADDR_RES1) >> 2);
  wire [31:0] status_w = {26'd0, win_long_r, carr_r, boost_r, osc_en_r, sleep_r, lock_filt_r};
  wire        hit      = (paddr == ADDR_CMD) || (paddr == ADDR_RESP) || (paddr == ADDR_STATUS)
                         || (paddr == ADDR_CTRL) || res_hit;
  wire [31:0] rd_val   = (paddr == ADDR_RESP)   ? resp_r :
                         (paddr == ADDR_STATUS) ? status_w :
                         (paddr == ADDR_CTRL)   ? {31'd0, sleep_r} :
                         res_hit                ? {24'd0, res_r[res_sel]} :
                                                  32'h0000_0000;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r  <= access & ~pready_r;
      prdata_r  <= (access && !pwrite && hit) ? rd_val : 32'h0000_0000;
      pslverr_r <= access & ~pready_r & ~hit;
    end
  end

  assign pready                 = pready_r;
  assign prdata                 = prdata_r;
  assign pslverr                = pslverr_r;
  assign adc_channel_sel        = ch_sel_r;
  assign adc_trial_code         = try_out_r;
  assign channel_two_select_b   = sel2b_r;
  assign channel_three_select_b = sel3b_r;
  assign carrier_detect_out     = carr_r;
  assign dac_one                = dac_one_r;
  assign dac_two                = dac_two_r;
  assign dac_three              = dac_three_r;
  assign dac_three_powered      = dac_three_on_r;
  assign dac_reduced_drive      = reduce_r;
  assign osc_enable             = osc_en_r;
  assign osc_boost              = boost_r;

endmodule

// ---- verification/rapd_top_assertions.sv ----
// checker for the converter control block, bound to its top module
// assumes one clock domain with synchronous active-high reset
module rapd_top_checker
  import rapd_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [2:0]  adc_channel_sel,
  input wire logic [7:0]  dac_one,
  input wire logic [7:0]  dac_two,
  input wire logic [7:0]  dac_three,
  input wire logic        channel_two_select_b,
  input wire logic        channel_three_select_b,
  input wire logic        dac_three_powered,
  input wire logic        dac_reduced_drive,
  input wire logic        osc_enable,
  input wire logic        osc_boost
);
  // --------------------
  // properties
  // --------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_chan_range : assert property (adc_channel_sel inside {[3'd1:3'd5]})
    else $error("channel out of range");
  a_five_between : assert property (
    $changed(adc_channel_sel) |-> ($past(adc_channel_sel) == 3'd5) != (adc_channel_sel == 3'd5))
    else $error("scan order broken");
  a_sleep_dac_three : assert property (dac_reduced_drive |-> !dac_three_powered)
    else $error("dac three powered in sleep");
  a_boost_start : assert property ($rose(osc_enable) |-> ##[0:2] osc_boost)
    else $error("no boost after enable");
  a_ready_wait : assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("ready latency wrong");
  a_ready_pulse : assert property (pready |=> !pready)
    else $error("ready too long");
  a_err_zero : assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error answer not clean");
  a_dac_cause : assert property (
    $changed({dac_one, dac_two, dac_three}) |-> $past(psel & pwrite) || $past(psel & pwrite, 2))
    else $error("dac changed without command");
  a_sel_cause : assert property (
    $changed({channel_two_select_b, channel_three_select_b})
      |-> $past(psel & pwrite) || $past(psel & pwrite, 2))
    else $error("select changed without command");

  c_err : cover property (pslverr);
  c_boost_end : cover property ($fell(osc_boost));
  c_dac_three_on : cover property (dac_three_powered);
endmodule

bind rapd_top rapd_top_checker rapd_top_checker_inst (
  .clock, .rst, .psel, .penable, .pwrite, .pready, .prdata, .pslverr, .adc_channel_sel,
  .dac_one, .dac_two, .dac_three, .channel_two_select_b, .channel_three_select_b,
  .dac_three_powered, .dac_reduced_drive, .osc_enable, .osc_boost
);

// ---- verification/rapd_far_model.sv ----
// far-side model: bus clock, crystal, analog levels and lock source
// assumes the converter compares the selected level with its trial code
module rapd_far_model
  import rapd_pkg::*;
#(
  parameter logic [55:0] LV = 56'h00_0000_0000_0000
)(
  input  wire logic [2:0] adc_channel_sel,
  input  wire logic [7:0] adc_trial_code,
  input  wire logic       channel_two_select_b,
  input  wire logic       channel_three_select_b,
  input  wire logic [1:0] lock_mode,
  output logic            serial_bus_clock,
  output logic            crystal_reference_clock,
  output logic            adc_comp_in,
  output logic            lock_raw
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] k;
  logic [1:0] cnt = 2'd0;
  logic       half = 1'b0;

  initial
  begin
    serial_bus_clock = 1'b0;
    forever #40 serial_bus_clock = ~serial_bus_clock;
  end
  initial
  begin
    crystal_reference_clock = 1'b0;
    forever #20 crystal_reference_clock = ~crystal_reference_clock;
  end

  // level index: ch1, 2a, 2b, 3a, 3b, ch4, ch5
  assign k = (adc_channel_sel == 3'd1) ? 3'd0 :
             (adc_channel_sel == 3'd2) ? 3'd1 + {2'b00, channel_two_select_b} :
             (adc_channel_sel == 3'd3) ? 3'd3 + {2'b00, channel_three_select_b} :
             (adc_channel_sel == 3'd4) ? 3'd5 : 3'd6;
  assign adc_comp_in = LV[8 * k +: 8] >= adc_trial_code;

  // half duty lock: two high samples in every four
  always @(negedge serial_bus_clock)
  begin
    cnt <= cnt + 2'd1;
    if (cnt == 2'd3)
      half <= ~half;
  end
  assign lock_raw = lock_mode[1] ? half : lock_mode[0];
endmodule

// ---- verification/rapd_top_tb_top.sv ----
// self-checking bench for the converter control block
// assumes the far-side model supplies clocks, comparator and lock
module rapd_top_tb_top
  import rapd_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [55:0] LV = 56'h00_FFE2_479D_213C;
  logic        clock, rst, psel, penable, pwrite, pready, pslverr, e;
  logic        serial_bus_clock, crystal_reference_clock, adc_comp_in, lock_raw;
  logic        channel_two_select_b, channel_three_select_b, carrier_detect_out;
  logic        dac_three_powered, dac_reduced_drive, osc_enable, osc_boost;
  logic [7:0]  paddr, adc_trial_code, dac_one, dac_two, dac_three;
  logic [31:0] pwdata, prdata, q;
  logic [2:0]  adc_channel_sel;
  logic [1:0]  lock_mode;
  int          errors, checked, xn;

  rapd_top rapd_top_inst (
    .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .serial_bus_clock, .crystal_reference_clock, .adc_comp_in, .lock_raw, .adc_channel_sel,
    .adc_trial_code, .channel_two_select_b, .channel_three_select_b, .carrier_detect_out,
    .dac_one, .dac_two, .dac_three, .dac_three_powered, .dac_reduced_drive, .osc_enable,
    .osc_boost
  );
  rapd_far_model #(.LV(LV)) rapd_far_model_inst (
    .adc_channel_sel, .adc_trial_code, .channel_two_select_b, .channel_three_select_b,
    .lock_mode, .serial_bus_clock, .crystal_reference_clock, .adc_comp_in, .lock_raw
  );

  // --------------------
  // helpers
  // --------------------
  task automatic final_report;
    if (errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic lim(input logic hit);
    if (hit)
    begin
      errors++;
      final_report();
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clock);
  endtask
  // one transfer, then an idle cycle before the next setup
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    lim(n == 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic cmd(input logic [7:0] d3, d2, d1);
    apb(1'b1, ADDR_CMD, {8'h00, d3, d2, d1});
    // one more edge so outputs registered behind the command have settled
    tk(1);
  endtask
  function automatic logic [7:0] lv(input int c, input int b);
    return LV[8 * ((c == 0) ? 0 : (c < 3) ? 2 * c - 1 + b : c + 2) +: 8];
  endfunction

  // --------------------
  // scenarios
  // --------------------
  task automatic t_reset;
    chk(dac_three_powered, 0);
    chk(osc_enable, 1);
    apb(1'b0, ADDR_STATUS, 0);
    chk(q & 32'h0000_003E, 32'h0000_000E);
    apb(1'b0, 8'h40, 0);
    chk(e, 1);
    chk(q, 0);
  endtask
  task automatic t_dac;
    cmd(8'h08, 8'h40, 8'h5A);
    cmd(8'h04, 8'h40, 8'hA5);
    cmd(8'h00, 8'h4A, 8'hFF);
    chk({dac_one, dac_two, dac_three, 7'h00, dac_three_powered}, 32'h5AA5_FF01);
    apb(1'b1, ADDR_CTRL, 1);
    tk(1);
    chk({dac_reduced_drive, dac_three_powered}, 2'b10);
    cmd(8'h00, 8'h40, 8'h11);
    chk({dac_one, dac_reduced_drive, dac_three_powered}, 10'h168);
  endtask
  task automatic t_scan(input int b);
    cmd(8'h80, b ? 8'h86 : 8'h80, 8'h00);
    chk({channel_two_select_b, channel_three_select_b}, b ? 2'b11 : 2'b00);
    tk(4200);
    for (int c = 0; c < 5; c++)
    begin
      apb(1'b0, ADDR_RES1 + 8'(4 * c), 0);
      chk(q, lv(c, b));
    end
  endtask
  task automatic t_resp;
    int n;
    for (int y = 0; y < 4; y++)
    begin
      cmd(8'(y), 8'h40, 8'h00);
      n = 0;
      do
      begin
        apb(1'b0, ADDR_RESP, 0);
        n++;
      end while (q[31] !== 1'b1 && n < 20);
      lim(n == 20);
      chk(q & 32'h80FF_FFFF, {4'h8, 4'h0, 4'hA, 2'(y), 2'b01, lv(4, 0), lv(y, 0)});
    end
  endtask
  task automatic lk(input logic [7:0] d3, d2, d1, input logic x);
    cmd(d3, d2, d1);
    tk(3000);
    apb(1'b0, ADDR_STATUS, 0);
    chk(q[ST_LOCK], x);
  endtask
  task automatic t_lock;
    lock_mode <= 2'b10;
    lk(8'h00, 8'h50, 8'h51, 1);
    lk(8'h00, 8'h50, 8'h52, 0);
    lock_mode <= 2'b01;
    lk(8'hA0, 8'h80, 8'h20, 1);
    chk(q[ST_WIN84], 1);
    // threshold raised only up to the window count
    lk(8'h00, 8'h50, 8'hA8, 1);
    lock_mode <= 2'b00;
    lk(8'h00, 8'h50, 8'hA8, 0);
  endtask
  task automatic t_carr;
    cmd(8'h10, 8'h40, 8'h3B);
    chk(carrier_detect_out, 1);
    cmd(8'h10, 8'h40, 8'h3C);
    chk(carrier_detect_out, 0);
  endtask
  task automatic t_osc;
    int n;
    n = 0;
    cmd(8'h00, 8'h80, 8'h00);
    chk(osc_enable, 0);
    cmd(8'h80, 8'h80, 8'h00);
    xn = 0;
    chk({osc_enable, osc_boost}, 2'b11);
    while (osc_boost === 1'b1 && n < 12000)
    begin
      tk(1);
      n++;
    end
    lim(n == 12000);
    chk(xn >= 2045 && xn <= 2050, 1);
  endtask
  task automatic t_restart;
    cmd(8'h08, 8'h40, 8'h77);
    cmd(8'h03, 8'h80, 8'h00);
    tk(2);
    chk({dac_one, dac_reduced_drive, osc_enable, osc_boost}, 11'h007);
  endtask

  // --------------------
  // run
  // --------------------
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge crystal_reference_clock) xn <= xn + 1;

  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    lock_mode = 2'b00;
    errors = 0;
    checked = 0;
    xn = 0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_dac();
    t_scan(1);
    t_scan(0);
    t_resp();
    t_lock();
    t_carr();
    t_osc();
    t_restart();
    final_report();
  end
endmodule
